// ==== logic/reference_input_meter_consts.svh ====
// constants shared by both ends of the reference clock meter link
`ifndef REFERENCE_INPUT_METER_CONSTS_SVH
`define REFERENCE_INPUT_METER_CONSTS_SVH
`define SLAVE_ADDR 7'h50
`define SUB_RATE_HIGH 3'h0
`define SUB_RATE_MID 3'h1
`define SUB_RATE_LOW 3'h2
`define SUB_COARSE 3'h3
`define SUB_MISC 3'h4
`define SUB_REF_CTRL 3'h5
`define SUB_SECOND_CTRL 3'h6
`define SUB_THIRD_CTRL 3'h7
`define SUB_LAST 3'h7
`define REF_LOCK_BIT 0
`define REF_MEAS_BIT 1
`define REF_RATIO_MSB 5
`define REF_RATIO_LSB 2
`define REF_RANGE_MSB 7
`define REF_RANGE_LSB 6
`define MEAS_RESTART_BIT 3
`define ACQ_RESTART_BIT 5
`define LOS_POL_BIT 2
`define MISC_COARSE_BIT 0
`define MISC_LOL_BIT 1
`define MISC_DONE_BIT 2
`define CTRL_RESET 8'h00
`define MEAS_BASE_TICKS 16384
`define BYTE_BITS 4'h8
`define ACK_DONE 4'h9
`define HOST_CMD_ADDR 12'h000
`define HOST_STAT_ADDR 12'h004
`define HOST_QTR 4
`endif

// ==== logic/reference_input_meter_host.sv ====
// host end: APB command registers driving the two-wire link
`timescale 1ns/1ps
`default_nettype none
`include "reference_input_meter_consts.svh"
module reference_input_meter_host
  import reference_input_meter_pkg::*;
#(
  parameter int QTR = `HOST_QTR,
  parameter logic [6:0] DEV_ADDR = `SLAVE_ADDR
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // register link
  two_wire_if.host link
);
  host_state_e state;
  host_op_e op;
  logic [$clog2(QTR)-1:0] qcnt;
  logic [1:0] phase, idx;
  logic [3:0] bitn;
  logic [2:0] sub;
  logic [7:0] wdata, rx, txb;
  logic [1:0] sda_s;
  logic nack, refused, scl, sda_zero, tick, rx_mode, acc, go;

  assign tick = (state != h_idle) && (qcnt == ($clog2(QTR))'(QTR - 1));
  assign rx_mode = (op == op_read) && (idx == 2'h1);
  assign txb = (idx == 2'h0) ? {DEV_ADDR, op == op_read} :
    (idx == 2'h1) ? {5'h00, sub} : wdata;
  assign acc = psel & penable & pready;
  assign go = acc & pwrite & (paddr == `HOST_CMD_ADDR) & (state == h_idle);

  // APB answer one cycle into the access phase
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != `HOST_CMD_ADDR) &
        (paddr != `HOST_STAT_ADDR);
      prdata <= 32'h00000000;
      if (psel && !penable && paddr == `HOST_STAT_ADDR)
        prdata <= {16'h0000, rx, 5'h00, refused, nack, state != h_idle};
    end
  end

  // pin sync and constant low data for the open drain
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sda_s <= 2'h3;
      sda_zero <= 1'b0;
    end
    else
    begin
      sda_s <= {sda_s[0], link.sda};
      sda_zero <= 1'b0;
    end
  end
  assign link.sda_host_out = sda_zero;
  assign link.sck = scl;

  // quarter-bit timing from the system clock
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      qcnt <= '0;
      phase <= 2'h0;
    end
    else if (state == h_idle)
    begin
      qcnt <= '0;
      phase <= 2'h0;
    end
    else if (tick)
    begin
      qcnt <= '0;
      phase <= phase + 2'h1;
    end
    else
      qcnt <= qcnt + ($clog2(QTR))'(1);
  end

  // transfer sequencer
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= h_idle;
      op <= op_write;
      sub <= 3'h0;
      wdata <= 8'h00;
      rx <= 8'h00;
      idx <= 2'h0;
      bitn <= 4'h0;
      nack <= 1'b0;
      refused <= 1'b0;
      scl <= 1'b1;
      link.sda_host_oe <= 1'b0;
    end
    else if (go)
    begin
      refused <= 1'b0;
      // both mode bits together never leave the host
      if (pwdata[13:12] == op_write && pwdata[10:8] == `SUB_REF_CTRL &&
        pwdata[`REF_LOCK_BIT] && pwdata[`REF_MEAS_BIT])
        refused <= 1'b1;
      else if (pwdata[13:12] != 2'h3)
      begin
        op <= host_op_e'(pwdata[13:12]);
        sub <= pwdata[10:8];
        wdata <= pwdata[7:0];
        state <= h_start;
        idx <= 2'h0;
        bitn <= 4'h0;
        nack <= 1'b0;
      end
      else
        refused <= 1'b1;
    end
    else if (tick)
    begin
      unique case (state)
        h_start:
          unique case (phase)
            2'h1: link.sda_host_oe <= 1'b1;
            2'h2: scl <= 1'b0;
            2'h3: state <= h_bits;
            default: ;
          endcase
        h_bits:
          unique case (phase)
            2'h0: link.sda_host_oe <= (bitn < `BYTE_BITS) && !rx_mode &&
              !txb[3'(4'h7 - bitn)];
            2'h1: scl <= 1'b1;
            2'h2:
            begin
              if (bitn < `BYTE_BITS && rx_mode)
                rx <= {rx[6:0], sda_s[1]};
              if (bitn == `BYTE_BITS && !rx_mode && sda_s[1])
                nack <= 1'b1;
            end
            2'h3:
            begin
              scl <= 1'b0;
              if (bitn != `BYTE_BITS)
                bitn <= bitn + 4'h1;
              else
              begin
                bitn <= 4'h0;
                if (nack || idx == ((op == op_write) ? 2'h2 : 2'h1))
                  state <= h_stop;
                else
                  idx <= idx + 2'h1;
              end
            end
          endcase
        h_stop:
          unique case (phase)
            2'h0: link.sda_host_oe <= 1'b1;
            2'h1: scl <= 1'b1;
            2'h2: link.sda_host_oe <= 1'b0;
            2'h3: state <= h_idle;
          endcase
        default: ;
      endcase
    end
  end
endmodule : reference_input_meter_host
`default_nettype wire

// ==== logic/reference_input_meter_pkg.sv ====
// types shared by both ends of the reference clock meter link
package reference_input_meter_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_addr = 3'b001,
    st_sub = 3'b010,
    st_wdat = 3'b011,
    st_rdat = 3'b100
  } dev_state_e;
  typedef enum logic [1:0] {
    h_idle = 2'b00,
    h_start = 2'b01,
    h_bits = 2'b10,
    h_stop = 2'b11
  } host_state_e;
  typedef enum logic [1:0] {
    op_write = 2'b00,
    op_point = 2'b01,
    op_read = 2'b10
  } host_op_e;
endpackage : reference_input_meter_pkg

// ==== logic/reference_input_rate_meter_dev.sv ====
// meter device end: two-wire register slave, modes and rate measurement
`timescale 1ns/1ps
`default_nettype none
`include "reference_input_meter_consts.svh"
module reference_input_rate_meter_dev
  import reference_input_meter_pkg::*;
#(
  parameter int MEAS_TICKS = `MEAS_BASE_TICKS,
  parameter logic [6:0] DEV_ADDR = `SLAVE_ADDR
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register link
  two_wire_if.device link,
  // front end inputs
  input wire logic reference_input,
  input wire logic data_clk,
  input wire logic loss_of_lock,
  input wire logic los_detect,
  input wire logic [8:0] coarse_rate,
  // front end controls
  output logic lock_to_ref,
  output logic [3:0] lock_ratio,
  output logic [1:0] ref_range,
  output logic harmonic_det_en,
  output logic acq_restart,
  output logic loss_of_signal
);
  localparam int TW = $clog2(MEAS_TICKS + 1);
  dev_state_e state;
  logic [2:0] sck_s, sda_s, ref_s, dat_s, lol_s;
  logic [1:0] los_s;
  logic [8:0] coarse_s0, coarse_s1, coarse_q;
  logic [3:0] cnt;
  logic [7:0] shreg, tx;
  logic [2:0] ptr;
  logic [7:0] reference_control, second_control, third_control;
  logic meas_run, meas_done;
  logic [2:0] pre_cnt;
  logic [TW-1:0] tick_cnt;
  logic [22:0] data_cnt, measured_rate_value;
  logic sda_zero;
  logic sck_rise, sck_fall, start_c, stop_c, byte_done, ack_end;
  logic wr_en, meas_cmd, acq_cmd, lock_cmd, div_tick, win_end;
  logic ref_rise, dat_rise, lol_rise;
  logic [7:0] rd_byte;

  // edges of synchronised inputs; stage 0 only feeds stage 1
  assign sck_rise = sck_s[1] & ~sck_s[2];
  assign sck_fall = ~sck_s[1] & sck_s[2];
  assign start_c = sck_s[1] & sck_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_c = sck_s[1] & sck_s[2] & ~sda_s[2] & sda_s[1];
  assign ref_rise = ref_s[1] & ~ref_s[2];
  assign dat_rise = dat_s[1] & ~dat_s[2];
  assign lol_rise = lol_s[1] & ~lol_s[2];
  assign byte_done = sck_fall & (cnt == `BYTE_BITS);
  assign ack_end = sck_fall & (cnt == `ACK_DONE);
  assign wr_en = byte_done & (state == st_wdat);
  // one then zero written to a restart bit fires it; the lock bit fires on zero then one
  assign meas_cmd = wr_en & (ptr == `SUB_SECOND_CTRL) &
    second_control[`MEAS_RESTART_BIT] & ~shreg[`MEAS_RESTART_BIT];
  assign acq_cmd = wr_en & (ptr == `SUB_SECOND_CTRL) &
    second_control[`ACQ_RESTART_BIT] & ~shreg[`ACQ_RESTART_BIT];
  assign lock_cmd = wr_en & (ptr == `SUB_REF_CTRL) &
    ~reference_control[`REF_LOCK_BIT] & shreg[`REF_LOCK_BIT];

  // two-flop synchronisers for every pin from outside
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sck_s <= 3'h7;
      sda_s <= 3'h7;
      ref_s <= 3'h0;
      dat_s <= 3'h0;
      lol_s <= 3'h0;
      los_s <= 2'h0;
      coarse_s0 <= 9'h000;
      coarse_s1 <= 9'h000;
    end
    else
    begin
      sck_s <= {sck_s[1:0], link.sck};
      sda_s <= {sda_s[1:0], link.sda};
      ref_s <= {ref_s[1:0], reference_input};
      dat_s <= {dat_s[1:0], data_clk};
      lol_s <= {lol_s[1:0], loss_of_lock};
      los_s <= {los_s[0], los_detect};
      coarse_s0 <= coarse_rate;
      coarse_s1 <= coarse_s0;
    end
  end

  // register read mux
  function automatic logic [7:0] read_reg(input logic [2:0] sub);
    logic [7:0] v;
    v = 8'h00;
    unique case (sub)
      `SUB_RATE_HIGH: v = {1'b0, measured_rate_value[22:16]};
      `SUB_RATE_MID: v = measured_rate_value[15:8];
      `SUB_RATE_LOW: v = measured_rate_value[7:0];
      `SUB_COARSE: v = coarse_q[8:1];
      `SUB_MISC:
      begin
        v[`MISC_COARSE_BIT] = coarse_q[0];
        v[`MISC_LOL_BIT] = lol_s[2];
        v[`MISC_DONE_BIT] = meas_done;
      end
      `SUB_REF_CTRL: v = reference_control;
      `SUB_SECOND_CTRL: v = second_control;
      `SUB_THIRD_CTRL: v = third_control;
    endcase
    return v;
  endfunction : read_reg

  // byte that the next read slot loads from the pointer
  assign rd_byte = read_reg(ptr);

  // slave protocol: start and stop abort any transfer
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= st_idle;
      cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'h00;
      ptr <= 3'h0;
      link.sda_dev_oe <= 1'b0;
    end
    else if (start_c)
    begin
      state <= st_addr;
      cnt <= 4'h0;
      link.sda_dev_oe <= 1'b0;
    end
    else if (stop_c)
    begin
      state <= st_idle;
      link.sda_dev_oe <= 1'b0;
    end
    else if (state != st_idle)
    begin
      if (sck_rise && cnt < `BYTE_BITS)
      begin
        shreg <= {shreg[6:0], sda_s[1]};
        tx <= {tx[6:0], 1'b0};
        cnt <= cnt + 4'h1;
      end
      else if (sck_rise && cnt == `ACK_DONE && state == st_rdat &&
        sda_s[1])
        state <= st_idle; // master refused: end of read
      if (byte_done)
      begin
        cnt <= `ACK_DONE;
        link.sda_dev_oe <= 1'b0;
        unique case (state)
          st_addr:
          begin
            if (shreg[7:1] == DEV_ADDR)
            begin
              link.sda_dev_oe <= 1'b1;
              state <= shreg[0] ? st_rdat : st_sub;
            end
            else
              state <= st_idle;
          end
          st_sub:
          begin
            link.sda_dev_oe <= 1'b1;
            ptr <= shreg[2:0];
            if (shreg[7:3] != 5'h00)
            begin
              link.sda_dev_oe <= 1'b0; // unknown subaddress: no ack
              state <= st_idle;
            end
            else
              state <= st_wdat;
          end
          st_wdat:
          begin
            link.sda_dev_oe <= 1'b1;
            if (ptr != `SUB_LAST)
              ptr <= ptr + 3'h1;
          end
          default:
            link.sda_dev_oe <= 1'b0;
        endcase
      end
      else if (ack_end)
      begin
        cnt <= 4'h0;
        link.sda_dev_oe <= 1'b0;
        if (state == st_rdat)
        begin
          tx <= rd_byte;
          link.sda_dev_oe <= ~rd_byte[7];
          if (ptr != `SUB_LAST)
            ptr <= ptr + 3'h1; // last register repeats
        end
      end
      else if (sck_fall && state == st_rdat && cnt < `BYTE_BITS)
        link.sda_dev_oe <= ~tx[7];
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      sda_zero <= 1'b0;
    else
      sda_zero <= 1'b0;
  end
  assign link.sda_dev_out = sda_zero;

  // control registers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reference_control <= `CTRL_RESET; // range 00 by default
      second_control <= `CTRL_RESET;
      third_control <= `CTRL_RESET;
    end
    else if (wr_en)
    begin
      unique case (ptr)
        `SUB_REF_CTRL: reference_control <= shreg;
        `SUB_SECOND_CTRL: second_control <= shreg;
        `SUB_THIRD_CTRL: third_control <= shreg;
        default: ;
      endcase
    end
  end

  // lock control outputs toward the front end
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_to_ref <= 1'b0;
      lock_ratio <= 4'h0;
      ref_range <= 2'h0;
      harmonic_det_en <= 1'b1;
      acq_restart <= 1'b0;
      loss_of_signal <= 1'b0;
    end
    else
    begin
      lock_to_ref <= reference_control[`REF_LOCK_BIT];
      lock_ratio <= reference_control[`REF_RATIO_MSB:`REF_RATIO_LSB];
      ref_range <= reference_control[`REF_RANGE_MSB:`REF_RANGE_LSB];
      harmonic_det_en <= ~reference_control[`REF_LOCK_BIT];
      // relock on lost lock in reference mode
      acq_restart <= acq_cmd | lock_cmd |
        (reference_control[`REF_LOCK_BIT] & lol_rise);
      loss_of_signal <= los_s[1] ^ third_control[`LOS_POL_BIT];
    end
  end

  // coarse rate follows the input only while lock is present, held while lock is lost
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      coarse_q <= 9'h000;
    else if (!lol_s[2])
      coarse_q <= coarse_s1;
  end

  // reference divided into the base band, window of MEAS_TICKS ticks
  assign div_tick = ref_rise &&
    (pre_cnt == 3'((4'h1 << ref_range) - 4'h1));
  assign win_end = meas_run && div_tick &&
    (tick_cnt == TW'(MEAS_TICKS - 1));

  // measurement; independent of lock path
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meas_run <= 1'b0;
      meas_done <= 1'b0;
      pre_cnt <= 3'h0;
      tick_cnt <= '0;
      data_cnt <= 23'h000000;
      measured_rate_value <= 23'h000000;
    end
    else
    begin
      if (ref_rise)
        pre_cnt <= div_tick ? 3'h0 : pre_cnt + 3'h1;
      if (win_end)
      begin
        // data edges per 2^14 base-band ticks
        meas_run <= 1'b0;
        meas_done <= 1'b1; // set wins over a clear
        measured_rate_value <= data_cnt + 23'(dat_rise);
      end
      else if (meas_cmd)
      begin
        meas_done <= 1'b0;
        // enable bit is sampled only when the restart fires; clearing it later does not stop a run
        meas_run <= reference_control[`REF_MEAS_BIT];
        tick_cnt <= '0;
        data_cnt <= 23'h000000;
        pre_cnt <= 3'h0;
      end
      else if (meas_run)
      begin
        if (div_tick)
          tick_cnt <= tick_cnt + TW'(1);
        if (dat_rise)
          data_cnt <= data_cnt + 23'h000001;
      end
    end
  end
endmodule : reference_input_rate_meter_dev
`default_nettype wire

// ==== logic/two_wire_if.sv ====
// two-wire register link between host controller and meter device
`timescale 1ns/1ps
`default_nettype none
interface two_wire_if;
  logic sck;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic sda;
  // open drain with pull-up: any enabled low driver wins
  assign sda = !((sda_host_oe && !sda_host_out) ||
                 (sda_dev_oe && !sda_dev_out));
  modport host (output sck, output sda_host_out, output sda_host_oe,
    input sda);
  modport device (input sck, input sda, output sda_dev_out,
    output sda_dev_oe);
endinterface : two_wire_if
`default_nettype wire

// ==== testbench/reference_input_meter_chk.sv ====
// concurrent checks on the two-wire link and the mode outputs
`timescale 1ns/1ps
`default_nettype none
module reference_input_meter_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link wires
  input wire logic sck,
  input wire logic sda,
  input wire logic sda_dev_oe,
  // mode outputs and front end
  input wire logic lock_to_ref,
  input wire logic harmonic_det_en,
  input wire logic acq_restart,
  input wire logic loss_of_lock
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // lock loss while in reference mode
  sequence lol_rise_s;
    lock_to_ref && $rose(loss_of_lock);
  endsequence
  // restart pulse within the sync delay
  sequence restart_s;
    ##[1:6] acq_restart;
  endsequence
  harm_off_a: assert property (harmonic_det_en == !lock_to_ref)
    else $error("harmonic detector state wrong");
  relock_a: assert property (lol_rise_s |-> restart_s)
    else $error("no relock after loss of lock");
  lock_go_a: assert property ($rose(lock_to_ref) |->
    $past(acq_restart) or ##[0:1] acq_restart)
    else $error("no lock command on entering reference mode");
  pulse_one_a: assert property (acq_restart |=> !acq_restart)
    else $error("restart pulse longer than one cycle");
  dev_hold_a: assert property ($changed(sda_dev_oe) |-> !sck)
    else $error("device changed data while clock high");
  dev_ack_a: assert property ($rose(sda_dev_oe) |-> !$past(sck, 2))
    else $error("device drove data too soon after clock fall");
  sck_high_a: assert property ($rose(sck) |=> sck [*3])
    else $error("link clock high phase too short");
  sck_low_a: assert property ($fell(sck) |=> !sck [*3])
    else $error("link clock low phase too short");
  start_a: assert property ($fell(sda) && sck |-> ##[1:8] !sck)
    else $error("start not followed by clock fall");
endmodule : reference_input_meter_chk
`default_nettype wire

// ==== testbench/reference_input_mode_and_rate_meter_tb.sv ====
// self-checking bench for both ends of the reference clock meter
`timescale 1ns/1ps
`default_nettype none
`include "reference_input_meter_consts.svh"
module reference_input_mode_and_rate_meter_tb
  import reference_input_meter_pkg::*;
;
  localparam int MT = 64;
  typedef struct packed {logic [1:0] rng; logic [22:0] res;} row_s;
  logic sys_clk, resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic reference_input, data_clk, loss_of_lock, los_detect;
  logic lock_to_ref, harmonic_det_en, acq_restart, loss_of_signal;
  logic [8:0] coarse_rate;
  logic [3:0] lock_ratio;
  logic [1:0] ref_range;
  logic [2:0] div;
  logic [7:0] b;
  logic [22:0] r;
  int err_total, total_checks, n_rst, n0, tl;
  // data runs at twice the reference, so a window of MT base ticks
  // holds MT*2 data edges per unit of range scaling
  row_s rows[4] = '{'{2'h0, 23'(MT * 2)}, '{2'h1, 23'(MT * 4)},
    '{2'h2, 23'(MT * 8)}, '{2'h3, 23'(MT * 16)}};
  two_wire_if two_wire_if_i ();
  reference_input_meter_host reference_input_meter_host_i (.sys_clk(sys_clk),
    .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(two_wire_if_i));
  reference_input_rate_meter_dev #(.MEAS_TICKS(MT)) reference_input_rate_meter_dev_i (
    .sys_clk(sys_clk), .resetn(resetn), .link(two_wire_if_i),
    .reference_input(reference_input), .data_clk(data_clk),
    .loss_of_lock(loss_of_lock), .los_detect(los_detect),
    .coarse_rate(coarse_rate), .lock_to_ref(lock_to_ref),
    .lock_ratio(lock_ratio), .ref_range(ref_range),
    .harmonic_det_en(harmonic_det_en), .acq_restart(acq_restart),
    .loss_of_signal(loss_of_signal));
  reference_input_meter_chk reference_input_meter_chk_i (.sys_clk(sys_clk),
    .resetn(resetn), .sck(two_wire_if_i.sck), .sda(two_wire_if_i.sda),
    .sda_dev_oe(two_wire_if_i.sda_dev_oe), .lock_to_ref(lock_to_ref),
    .harmonic_det_en(harmonic_det_en), .acq_restart(acq_restart),
    .loss_of_lock(loss_of_lock));
  // system clock
  initial
  begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  // far-side clocks: reference 8 cycles, data 4 cycles
  always @(posedge sys_clk)
  begin
    div <= div + 3'h1;
    reference_input <= div[2];
    data_clk <= div[1];
  end
  // counts restart pulses
  always @(posedge sys_clk)
    if (acq_restart === 1'h1)
      n_rst <= n_rst + 1;
  // compares and counts
  task automatic chk(input string nm, input logic [31:0] s,
    input logic [31:0] x);
    total_checks = total_checks + 1;
    if (s !== x)
    begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // one apb transfer, result left in q and e
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1)
      @(posedge sys_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // one link job, then poll busy; status left in q
  task automatic job(input host_op_e op, input logic [2:0] s,
    input logic [7:0] d);
    apb(1'h1, `HOST_CMD_ADDR, {18'h0, op, 1'h0, s, d});
    q = 32'h1;
    while (q[0] !== 1'h0)
      apb(1'h0, `HOST_STAT_ADDR, 32'h0);
  endtask : job
  // read one device register, optionally setting the pointer first
  task automatic rd(input logic pt, input logic [2:0] s);
    if (pt)
      job(op_point, s, 8'h00);
    job(op_read, 3'h0, 8'h00);
    b = q[15:8];
  endtask : rd
  // prints counts and verdict, ends the run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  // watchdog sized well above the expected run of some 30k cycles
  initial
  begin
    #9000000;
    err_total = err_total + 1;
    finish_test();
  end
  // main sequence
  initial
  begin
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    loss_of_lock = 1'h0;
    los_detect = 1'h0;
    coarse_rate = 9'h1a5;
    reference_input = 1'h0;
    data_clk = 1'h0;
    div = 3'h0;
    n_rst = 0;
    err_total = 0;
    total_checks = 0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk("harm_en", harmonic_det_en, 1'h1);
    chk("lock_rst", lock_to_ref, 1'h0);
    rd(1'h1, `SUB_REF_CTRL);
    chk("ref_ctrl", b, 8'h00);
    rd(1'h0, 3'h0);
    chk("ctrl2", b, 8'h00);
    rd(1'h0, 3'h0);
    chk("ctrl3", b, 8'h00);
    apb(1'h0, 12'h008, 32'h0);
    chk("slverr", e, 1'h1);
    chk("unmapped", q, 32'h0);
    rd(1'h1, `SUB_COARSE);
    chk("coarse_hi", b, 8'hd2);
    rd(1'h0, 3'h0);
    chk("coarse_lsb", b[1:0], 2'h1);
    $display("test reset and coarse done");
    los_detect <= 1'h1;
    repeat (6) @(posedge sys_clk);
    chk("los_high", loss_of_signal, 1'h1);
    job(op_write, `SUB_THIRD_CTRL, 8'h04);
    chk("los_low", loss_of_signal, 1'h0);
    los_detect <= 1'h0;
    repeat (6) @(posedge sys_clk);
    chk("los_idle", loss_of_signal, 1'h1);
    job(op_write, `SUB_THIRD_CTRL, 8'h00);
    $display("test los polarity done");
    foreach (rows[k])
    begin
      n0 = n_rst;
      tl = (2 << k) + 2;
      job(op_write, `SUB_REF_CTRL, {rows[k].rng, 6'h02});
      job(op_write, `SUB_SECOND_CTRL, 8'h08);
      job(op_write, `SUB_SECOND_CTRL, 8'h00);
      rd(1'h1, `SUB_MISC);
      if (k >= 2)
        chk("done_clear", b[2], 1'h0);
      while (b[2] !== 1'h1)
        rd(1'h1, `SUB_MISC);
      chk("lol_low", b[1], 1'h0);
      rd(1'h1, `SUB_RATE_HIGH);
      r[22:16] = b[6:0];
      rd(1'h0, 3'h0);
      r[15:8] = b;
      rd(1'h0, 3'h0);
      r[7:0] = b;
      chk("rate", 32'((r + tl >= rows[k].res) && (r <= rows[k].res + tl)),
        32'h1);
      chk("no_lock", lock_to_ref, 1'h0);
      chk("no_restart", n_rst, n0);
      $display("test rate row %0d done", k);
    end
    n0 = n_rst;
    job(op_write, `SUB_REF_CTRL, 8'h00);
    job(op_write, `SUB_REF_CTRL, 8'he1);
    chk("lock_on", lock_to_ref, 1'h1);
    chk("ratio", lock_ratio, 4'h8);
    chk("range", ref_range, 2'h3);
    chk("harm_off", harmonic_det_en, 1'h0);
    chk("lock_cmd", n_rst, n0 + 1);
    loss_of_lock <= 1'h1;
    repeat (8) @(posedge sys_clk);
    chk("relock", n_rst, n0 + 2);
    rd(1'h1, `SUB_MISC);
    chk("lol_bit", b[1], 1'h1);
    loss_of_lock <= 1'h0;
    job(op_write, `SUB_SECOND_CTRL, 8'h20);
    chk("held_one", n_rst, n0 + 2);
    job(op_write, `SUB_SECOND_CTRL, 8'h00);
    chk("acq_restart", n_rst, n0 + 3);
    chk("mode_kept", lock_to_ref, 1'h1);
    job(op_write, `SUB_REF_CTRL, 8'h03);
    chk("refused", q[2], 1'h1);
    chk("still_lock", lock_to_ref, 1'h1);
    job(op_write, `SUB_REF_CTRL, 8'h00);
    chk("harm_back", harmonic_det_en, 1'h1);
    $display("test lock mode done");
    // reset in mid-run must restore the default polarity
    job(op_write, `SUB_THIRD_CTRL, 8'h04);
    chk("los_inv", loss_of_signal, 1'h1);
    resetn <= 1'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk("los_rst", loss_of_signal, 1'h0);
    rd(1'h1, `SUB_THIRD_CTRL);
    chk("ctrl3_rst", b, 8'h00);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule : reference_input_mode_and_rate_meter_tb
`default_nettype wire
